// ---- core/asrp_serial_port.sv ----
// Serial result port of a 16-bit converter sharing pins with the parallel bus.
// Assumes conversion results arrive on clk; all pins are asynchronous to clk.
`timescale 1ns/10ps
module asrp_serial_port (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic [15:0]       conv_result,
  input  wire logic              conv_done,
  input  wire logic              conv_busy,
  input  wire logic              serial_parallel_select,
  input  wire logic              clock_source_select,
  input  wire logic              output_coding_select,
  input  wire logic              clock_invert_select,
  input  wire logic              frame_polarity_select,
  input  wire logic              cs_n,
  input  wire logic              rd_n,
  input  wire logic              chain_in_or_read_mode,
  input  wire logic              sclk_in,
  output asrp_pkg::asrp_pin_t    parallel_bit_seven,
  output asrp_pkg::asrp_pin_t    parallel_bit_eight,
  output asrp_pkg::asrp_pin_t    parallel_bit_nine,
  output logic                   frame_sync_out
);
  import asrp_pkg::*;

  asrp_pins_t  meta_q, pin_q;
  logic        sclk_prev_q;
  logic [15:0] result_q, result_d;
  logic        pend_q, pend_d;
  logic [15:0] shift_q, shift_d;
  logic [4:0]  cnt_q, cnt_d;
  logic [1:0]  ph_q, ph_d;
  logic [7:0]  tick_q, tick_d;
  logic        chain_q, chain_d;
  logic        sclk_q, sclk_d;
  asrp_state_t st_q, st_d;
  asrp_pin_t   p7_d, p8_d, p9_d;
  logic        fs_d;
  logic        rdy_d, err_d;
  logic [31:0] rdata_d;
  logic [7:0]  div_q, div_d;
  logic [15:0] word;
  logic        read_en, rise, fall, upd_edge, smp_edge, tick, m_start, s_start;

  // Two flops on every pin input; only the second stage is read by logic.
  always_ff @(posedge clk)
  begin
    meta_q      <= {serial_parallel_select, clock_source_select, output_coding_select,
                    clock_invert_select, frame_polarity_select, cs_n, rd_n,
                    chain_in_or_read_mode, sclk_in};
    pin_q       <= meta_q;
    sclk_prev_q <= pin_q.sclk;
  end

  // Decoded conditions shared by the shifter and the pin drivers.
  always_comb
  begin
    word     = pin_q.bin_code ? result_q : {~result_q[15], result_q[14:0]}; // [RULE8] [RULE14]
    read_en  = !pin_q.cs_n && !pin_q.rd_n;
    rise     = pin_q.sclk && !sclk_prev_q;
    fall     = !pin_q.sclk && sclk_prev_q;
    upd_edge = pin_q.inv_clk ? fall : rise; // [RULE10]
    smp_edge = pin_q.inv_clk ? rise : fall; // [RULE10]
    tick     = (tick_q == div_q);
    // Read mode high may start while a conversion runs; low waits for it to end.
    m_start  = pin_q.sp_sel && !pin_q.ext_clk && read_en && pend_q
               && (pin_q.chain || !conv_busy); // [RULE2] [RULE5] [RULE13]
    s_start  = pin_q.sp_sel && pin_q.ext_clk && read_en && pend_q; // [RULE2] [RULE13]
  end

  // Result holding, shifter state machine and internal clock generator.
  always_comb
  begin
    result_d = conv_done ? conv_result : result_q;
    pend_d   = pend_q;
    st_d     = st_q;
    shift_d  = shift_q;
    cnt_d    = cnt_q;
    ph_d     = ph_q;
    sclk_d   = sclk_q;
    chain_d  = chain_q;
    tick_d   = (tick || st_q != ST_MSHIFT) ? 8'h00 : tick_q + 8'h01;
    case (st_q)
      ST_IDLE:
      begin
        sclk_d = 1'b0;
        ph_d   = 2'h0;
        cnt_d  = 5'h00;
        if (m_start || s_start)
        begin
          shift_d = word; // [RULE7]
          // The first chained bit is the level at read start, not one left from a past frame.
          chain_d = pin_q.chain; // [RULE3]
          pend_d  = 1'b0;
          st_d    = m_start ? ST_MSHIFT : ST_SSHIFT;
        end
      end
      ST_MSHIFT:
      begin
        // Data moves one phase after the falling edge and one before the rising edge,
        // so the host may sample on either edge.
        if (tick)
        begin
          ph_d = ph_q + 2'h1;
          if (ph_d == PH_RISE)
            sclk_d = 1'b1;
          if (ph_d == PH_FALL)
            sclk_d = 1'b0;
          if (ph_q == PH_LAST)
          begin
            if (cnt_q == LAST_BIT)
              st_d = ST_IDLE;
            cnt_d   = cnt_q + 5'h01;
            shift_d = {shift_q[14:0], 1'b0}; // [RULE7] [RULE9]
          end
        end
        if (!read_en || !pin_q.sp_sel || pin_q.ext_clk)
          st_d = ST_IDLE;
      end
      ST_SSHIFT:
      begin
        // Chain bit is taken at the sampling edge, so it is stable when we shift.
        if (smp_edge)
          chain_d = pin_q.chain; // [RULE3]
        if (upd_edge)
        begin
          shift_d = {shift_q[14:0], chain_q}; // [RULE4] [RULE7] [RULE10]
          if (cnt_q != CHAIN_BIT)
            cnt_d = cnt_q + 5'h01;
        end
        if (!read_en || !pin_q.sp_sel || !pin_q.ext_clk)
          st_d = ST_IDLE;
      end
      default:
        st_d = ST_IDLE;
    endcase
    if (conv_done)
      pend_d = 1'b1; // A new result wins over the clear at read start.
  end

  // Pin drivers; all pins leave the block through flops.
  // Serial data takes the next shifter value, so it never moves together with a clock edge.
  always_comb
  begin
    p7_d.o  = word[7];
    p7_d.oe = !pin_q.sp_sel && read_en; // [RULE1] [RULE2]
    p8_d.o  = pin_q.sp_sel ? shift_d[15] : word[8]; // [RULE6] [RULE7]
    p8_d.oe = read_en;
    p9_d.o  = pin_q.sp_sel ? (sclk_d ^ pin_q.inv_clk) : word[9]; // [RULE11] [RULE13]
    p9_d.oe = pin_q.sp_sel ? !pin_q.ext_clk : read_en; // [RULE11] [RULE12]
    fs_d    = (st_d == ST_MSHIFT) ^ pin_q.inv_frame; // [RULE16]
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      result_q           <= 16'h0000;
      pend_q             <= 1'b0;
      st_q               <= ST_IDLE;
      shift_q            <= 16'h0000;
      cnt_q              <= 5'h00;
      ph_q               <= 2'h0;
      tick_q             <= 8'h00;
      chain_q            <= 1'b0;
      sclk_q             <= 1'b0;
      parallel_bit_seven <= '0;
      parallel_bit_eight <= '0;
      parallel_bit_nine  <= '0;
      frame_sync_out     <= 1'b0;
    end
    else
    begin
      result_q           <= result_d;
      pend_q             <= pend_d;
      st_q               <= st_d;
      shift_q            <= shift_d;
      cnt_q              <= cnt_d;
      ph_q               <= ph_d;
      tick_q             <= tick_d;
      chain_q            <= chain_d;
      sclk_q             <= sclk_d;
      parallel_bit_seven <= p7_d;
      parallel_bit_eight <= p8_d;
      parallel_bit_nine  <= p9_d;
      frame_sync_out     <= fs_d;
    end
  end

  // APB slave with one wait state; the answer comes from flops.
  always_comb
  begin
    rdy_d   = psel && penable && !pready;
    err_d   = 1'b0;
    rdata_d = 32'h0000_0000;
    div_d   = div_q;
    case (paddr)
      ADDR_CTRL:   rdata_d = {24'h00_0000, div_q};
      ADDR_STATUS: rdata_d = {21'h00_0000, pin_q.ext_clk, pin_q.sp_sel, pend_q, cnt_q, st_q};
      ADDR_RESULT: rdata_d = {16'h0000, word};
      default:     err_d   = 1'b1;
    endcase
    if (!rdy_d)
    begin
      rdata_d = 32'h0000_0000;
      err_d   = 1'b0;
    end
    if (psel && penable && pready && pwrite && paddr == ADDR_CTRL)
      div_d = pwdata[7:0];
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      div_q   <= DIV_RST;
    end
    else
    begin
      pready  <= rdy_d;
      pslverr <= err_d;
      prdata  <= rdata_d;
      div_q   <= div_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_bit7_parallel;
    !pin_q.sp_sel && read_en |=> parallel_bit_seven.oe && parallel_bit_seven.o == $past(word[7]);
  endproperty
  a_bit7_parallel: assert property (p_bit7_parallel) else $error("bit seven not driven"); // [RULE1]

  property p_bit7_input;
    pin_q.sp_sel |=> !parallel_bit_seven.oe;
  endproperty
  a_bit7_input: assert property (p_bit7_input) else $error("chain pin driven in serial"); // [RULE2]

  property p_chain_out;
    st_q == ST_SSHIFT && st_d == ST_SSHIFT && upd_edge && cnt_q == LAST_BIT
      ##1 st_q == ST_SSHIFT |=> parallel_bit_eight.o == $past(chain_q, 2);
  endproperty
  a_chain_out: assert property (p_chain_out) else $error("chain bit late"); // [RULE3] [RULE4]

  property p_read_mode;
    st_q == ST_IDLE && st_d == ST_MSHIFT && !pin_q.chain |-> !conv_busy;
  endproperty
  a_read_mode: assert property (p_read_mode) else $error("read during conversion"); // [RULE5]

  property p_bit8_parallel;
    !pin_q.sp_sel |=> parallel_bit_eight.o == $past(word[8]);
  endproperty
  a_bit8_parallel: assert property (p_bit8_parallel) else $error("bit eight wrong"); // [RULE6]

  property p_msb_first;
    st_q == ST_IDLE && st_d != ST_IDLE
      |=> shift_q == $past(word) && parallel_bit_eight.o == $past(word[15]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("msb not first"); // [RULE7] [RULE8]

  property p_stable_edges;
    st_q == ST_MSHIFT && $changed(sclk_q) |-> $stable(shift_q);
  endproperty
  a_stable_edges: assert property (p_stable_edges) else $error("data moved at edge"); // [RULE9]

  property p_slave_edge;
    st_q == ST_SSHIFT && $past(st_q) == ST_SSHIFT && $changed(shift_q) |-> $past(upd_edge);
  endproperty
  a_slave_edge: assert property (p_slave_edge) else $error("shift off edge"); // [RULE10]

  property p_sclk_pin;
    pin_q.sp_sel |=> parallel_bit_nine.oe == !$past(pin_q.ext_clk);
  endproperty
  a_sclk_pin: assert property (p_sclk_pin) else $error("clock pin direction"); // [RULE12]

  property p_frame;
    st_q == ST_MSHIFT |=> frame_sync_out == !$past(pin_q.inv_frame) || st_q != ST_MSHIFT;
  endproperty
  a_frame: assert property (p_frame) else $error("frame sync level"); // [RULE16]

  property p_bit9_parallel;
    !pin_q.sp_sel |=> parallel_bit_nine.o == $past(word[9])
      && parallel_bit_nine.oe == $past(read_en);
  endproperty
  a_bit9_parallel: assert property (p_bit9_parallel) else $error("bit nine wrong"); // [RULE11]

  property p_serial_data;
    pin_q.sp_sel |=> parallel_bit_eight.o == shift_q[15];
  endproperty
  a_serial_data: assert property (p_serial_data) else $error("serial pin off shifter"); // [RULE7]

  property p_master_clock;
    pin_q.sp_sel && !pin_q.ext_clk && st_q == ST_IDLE
      |=> parallel_bit_nine.o == $past(pin_q.inv_clk);
  endproperty
  a_master_clock: assert property (p_master_clock) else $error("idle clock level"); // [RULE13]

endmodule : asrp_serial_port

// ---- shared/asrp_pkg.sv ----
// Constants, states and carrier types of the converter's serial result port.
// Assumes one 200 MHz clock and registers reached over an APB slave.
//
// Behaviour
// RULE1: Serial/parallel select low makes the chain pin drive parallel bit seven.
// RULE2: In serial mode the chain pin is chain input or read mode, per clock source.
// RULE3: External clock selected: chain pin accepts upstream converter data for daisy chaining.
// RULE4: Chain input level reaches the serial output sixteen clock periods after read start.
// RULE5: Internal clock: read mode high shifts during conversion, low only after completion.
// RULE6: Serial/parallel select low makes the serial output pin drive parallel bit eight.
// RULE7: Stored result shifts out MSB first, synchronised to the serial clock.
// RULE8: Serial word coding follows the output coding select input.
// RULE9: Internal clock: each output bit stays stable across both clock edges.
// RULE10: External clock: update on rising edge, host samples falling; invert swaps edges.
// RULE11: Serial/parallel select low makes the serial clock pin drive parallel bit nine.
// RULE12: Serial clock pin is output with internal clock, input with external clock.
// RULE13: Clock source low drives internal clock out; high follows an external clock.
// RULE14: Coding select high gives straight binary; low inverts the MSB for two's complement.
// RULE15: Host holds chip select and read low to enable the output bus.
// RULE16: Internal clock: frame sync active while serial data valid; polarity select inverts.
package asrp_pkg;

  localparam int          RESULT_W    = 16;
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_RESULT = 12'h008;
  localparam logic [7:0]  DIV_RST     = 8'h03;
  localparam logic [4:0]  LAST_BIT    = 5'h0f;
  localparam logic [4:0]  CHAIN_BIT   = 5'h10;
  localparam logic [1:0]  PH_RISE     = 2'h1;
  localparam logic [1:0]  PH_FALL     = 2'h3;
  localparam logic [1:0]  PH_LAST     = 2'h3;

  // One-hot shifter states.
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_MSHIFT = 3'b010,
    ST_SSHIFT = 3'b100
  } asrp_state_t;

  // One drivable pin: output level and enable.
  typedef struct packed {
    logic o;
    logic oe;
  } asrp_pin_t;

  // Pin inputs that cross into the clock domain together.
  typedef struct packed {
    logic sp_sel;
    logic ext_clk;
    logic bin_code;
    logic inv_clk;
    logic inv_frame;
    logic cs_n;
    logic rd_n;
    logic chain;
    logic sclk;
  } asrp_pins_t;

endpackage : asrp_pkg

// ---- tb/asrp_host_model.sv ----
// Host serial port model: drives chip select, read and the slave link clock.
// Assumes the result port samples every pin on its own clock.
`timescale 1ns/10ps
module asrp_host_model (
  input  wire logic clk,
  input  wire logic sdo,
  input  wire logic inv,
  output logic      sclk,
  output logic      cs_n,
  output logic      rd_n
);
  logic [31:0] got;

  // Deselected at start; the link clock stands still between frames.
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    rd_n = 1'b1;
    got  = '0;
  end

  // Both lines low enable the port's output.
  task automatic hold(input logic en);
    @(posedge clk);
    cs_n <= ~en;
    rd_n <= ~en;
  endtask : hold

  // Clock n bits at 160 ns per period; a bit is taken just before the next update edge.
  task automatic read_bits(input int n);
    got = '0;
    @(posedge clk);
    sclk <= inv;
    repeat (4) @(posedge clk);
    hold(1'b1);
    repeat (8) @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      got = {got[30:0], sdo};
      sclk <= ~inv;
      repeat (16) @(posedge clk);
      sclk <= inv;
      repeat (16) @(posedge clk);
    end
    hold(1'b0);
  endtask : read_bits
endmodule : asrp_host_model

// ---- tb/asrp_serial_port_test.sv ----
// Self-checking bench of the serial result port: registers, parallel, slave, master.
// Assumes the host model drives chip select, read and the slave link clock.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module asrp_serial_port_test;
  import asrp_pkg::*;
  logic        clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic [15:0] conv_result = '0, w, c, r, f;
  logic        conv_done = 1'b0, conv_busy = 1'b0, sp = 1'b1, ext = 1'b1, ob = 1'b1;
  logic        inv = 1'b0, fp = 1'b0, chain = 1'b0, pready, pslverr, e, fs, cs_n, rd_n, sclk, p;
  logic [7:0]  v;
  asrp_pin_t   b7, b8, b9;
  int          bad_count = 0, checks_done = 0, nr, nf;
  logic [15:0] exp_q[$];

  asrp_serial_port dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .conv_result(conv_result), .conv_done(conv_done),
    .conv_busy(conv_busy), .serial_parallel_select(sp), .clock_source_select(ext),
    .output_coding_select(ob), .clock_invert_select(inv), .frame_polarity_select(fp),
    .cs_n(cs_n), .rd_n(rd_n), .chain_in_or_read_mode(chain), .sclk_in(sclk),
    .parallel_bit_seven(b7), .parallel_bit_eight(b8), .parallel_bit_nine(b9),
    .frame_sync_out(fs));

  asrp_host_model ph (.clk(clk), .sdo(b8.o), .inv(inv), .sclk(sclk), .cs_n(cs_n),
    .rd_n(rd_n));

  // Free-running 200 MHz clock.
  always #2.5 clk = ~clk;

  // Reference coding: straight binary, or the top bit inverted.
  function automatic logic [15:0] coded(input logic [15:0] x, input logic o);
    return o ? x : {~x[15], x[14:0]};
  endfunction : coded

  // One APB transfer; the request stands until pready is seen at an edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // A slave that never answers counts as a mismatch.
    if (pready !== 1'b1)
      bad_count++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Deliver one result; the expected coded word joins the model queue.
  task automatic convert(input logic [15:0] x, input logic o);
    @(posedge clk);
    conv_result <= x;
    conv_done <= 1'b1;
    exp_q.push_back(coded(x, o));
    @(posedge clk);
    conv_done <= 1'b0;
  endtask : convert

  // Print counts and verdict, then stop.
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  // Cuts a hang short well beyond the expected run of some 5k cycles.
  initial
  begin
    #300_000;
    bad_count++;
    results();
  end

  // Main sequence.
  initial
  begin
    void'($urandom(8657));
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b0, ADDR_CTRL, '0);
    `CHK("ctrl reset", {24'h0, DIV_RST}, q)
    v = 8'($urandom % 3);
    apb(1'b1, ADDR_CTRL, {24'hffff_ff, v});
    apb(1'b0, ADDR_CTRL, '0);
    `CHK("ctrl divider", {24'h0, v}, q)
    apb(1'b0, 12'h0fc, '0);
    `CHK("unmapped error", 1'b1, e)
    $display("test registers done");
    // Parallel mode: the shared pins carry bits seven to nine.
    sp <= 1'b0;
    ph.hold(1'b1);
    for (int k = 0; k < 2; k++)
    begin
      ob <= k[0];
      repeat (6) @(posedge clk);
      convert(16'($urandom), k[0]);
      repeat (6) @(posedge clk);
      c = exp_q.pop_front();
      `CHK("bit seven", {c[7], 1'b1}, b7)
      `CHK("bit eight", {c[8], 1'b1}, b8)
      `CHK("bit nine", {c[9], 1'b1}, b9)
      apb(1'b0, ADDR_RESULT, '0);
      `CHK("result reg", {16'h0, c}, q)
    end
    ph.hold(1'b0);
    $display("test parallel done");
    // Slave mode: every invert and coding setting, chain bits after the word.
    sp <= 1'b1;
    ext <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      inv <= k[0];
      ob <= k[1];
      chain <= 1'($urandom);
      repeat (6) @(posedge clk);
      convert(16'($urandom), k[1]);
      c = exp_q.pop_front();
      `CHK("sclk pin input", 1'b0, b9.oe)
      ph.read_bits(32);
      `CHK("slave word", {c, {16{chain}}}, ph.got)
    end
    $display("test slave done");
    // Master mode: read mode low waits for busy to fall; high reads during conversion.
    ext <= 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      inv <= k[0];
      chain <= k[0];
      conv_busy <= 1'b1;
      fp <= 1'($urandom);
      ph.hold(1'b1);
      repeat (6) @(posedge clk);
      convert(16'($urandom), ob);
      c = exp_q.pop_front();
      `CHK("sclk pin output", 1'b1, b9.oe)
      if (k == 0)
      begin
        repeat (40) @(posedge clk);
        `CHK("no frame while busy", fp, fs)
        conv_busy <= 1'b0;
      end
      nr = 0;
      nf = 0;
      p = b9.o;
      for (int t = 0; t < 4000 && (nr < 16 || nf < 16); t++)
      begin
        @(posedge clk);
        if (b9.o && !p)
        begin
          r = {r[14:0], b8.o};
          nr++;
          `CHK("frame active", ~fp, fs)
        end
        if (!b9.o && p)
        begin
          f = {f[14:0], b8.o};
          nf++;
        end
        p = b9.o;
      end
      conv_busy <= 1'b0;
      `CHK("master bits", 32, nr + nf)
      `CHK("master rise word", c, r)
      `CHK("master fall word", c, f)
      repeat (40) @(posedge clk);
      `CHK("frame idle", fp, fs)
      ph.hold(1'b0);
    end
    $display("test master done");
    results();
  end
endmodule : asrp_serial_port_test
